// [rtl/bsl_regs.svh]
// Register offsets, field positions and timing counts of the boot strap latch
`ifndef BSL_REGS_SVH
`define BSL_REGS_SVH
`define BSL_ADDR_W 4
`define BSL_OFF_STRAP 4'h0
`define BSL_OFF_BOOT 4'h4
`define BSL_OFF_CTRL 4'h8
`define BSL_BIT_SECONDARY 0
`define BSL_BIT_AUX 1
`define BSL_BIT_SELECT 2
`define BSL_BIT_VALID 3
`define BSL_BIT_FLASH 0
`define BSL_BIT_DOWNLOAD 1
`define BSL_BIT_INVALID 2
`define BSL_BIT_PRINT 3
`define BSL_BIT_RELEASE 0
`define BSL_PRINT_ALWAYS 2'h0
`define BSL_PRINT_AUX_LOW 2'h1
`define BSL_PRINT_AUX_HIGH 2'h2
`define BSL_PRINT_NEVER 2'h3
`define BSL_HOLD_NS 3000000
`define BSL_CLK_NS 10
`define BSL_HOLD_CYCLES ((`BSL_HOLD_NS + `BSL_CLK_NS - 1) / `BSL_CLK_NS)
`endif

// [rtl/bsl_pkg.sv]
// Types shared by the boot strap latch
package bsl_pkg;
    typedef struct packed {
        logic bootSelect;
        logic printAux;
        logic secondary;
    } bsl_strap_s;

    typedef enum logic [1:0] {
        BSL_BOOT_FLASH = 2'h0,
        BSL_BOOT_DOWNLOAD = 2'h1,
        BSL_BOOT_INVALID = 2'h2,
        BSL_BOOT_UNDEF = 2'h3
    } bsl_boot_e;

    typedef enum logic [1:0] {
        BSL_ST_SAMPLE = 2'h0,
        BSL_ST_HOLD = 2'h1,
        BSL_ST_RUN = 2'h2
    } bsl_state_e;
endpackage

// [rtl/bsl_strap_cell.sv]
// One strap latch bit with optional pull-up of a floating pin
`timescale 1ns/100ps
module bsl_strap_cell #(
    parameter bit PULL_UP = 1'b0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic capture,
    input wire logic padIn,
    input wire logic padDriven,
    output logic bitOut
);
    logic level;

    // Undriven pin reads the weak pull level
    assign level = padDriven ? padIn : PULL_UP;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bitOut <= PULL_UP;
        end else if (ce && capture) begin
            bitOut <= level;
        end
    end
endmodule // bsl_strap_cell

// [rtl/bsl_boot_strap_latch.sv]
// Boot strap latch: samples three strap pins in reset and decodes boot mode
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`include "bsl_regs.svh"
module bsl_boot_strap_latch #(
    parameter int HOLD_CYCLES = `BSL_HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic sysResetReq,
    input wire logic secondary_strap_pin,
    input wire logic print_aux_strap_pin,
    input wire logic boot_select_strap_pin,
    input wire logic bootSelectDriven,
    input wire logic [1:0] printControlFuse,
    input wire logic [`BSL_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic pinsReleased,
    output logic flashBoot,
    output logic downloadBoot,
    output logic strapInvalid,
    output logic romPrintEn
);
    bsl_pkg::bsl_strap_s straps;
    bsl_pkg::bsl_state_e state_reg;
    bsl_pkg::bsl_boot_e bootMode;
    logic [31:0] holdCnt_reg;
    logic capture;
    logic validReg;
    logic softRelease_reg;
    logic printEn;

    initial begin
        if (HOLD_CYCLES < 1) begin
            $error("HOLD_CYCLES must be at least one");
        end
    end

    // Sample only while reset sequence is active
    assign capture = (state_reg == bsl_pkg::BSL_ST_SAMPLE) || sysResetReq;

    bsl_strap_cell #(.PULL_UP(1'b0)) secondaryCell (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .capture(capture),
        .padIn(secondary_strap_pin),
        .padDriven(1'b1),
        .bitOut(straps.secondary)
    );
    bsl_strap_cell #(.PULL_UP(1'b0)) auxCell (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .capture(capture),
        .padIn(print_aux_strap_pin),
        .padDriven(1'b1),
        .bitOut(straps.printAux)
    );
    bsl_strap_cell #(.PULL_UP(1'b1)) selectCell (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .capture(capture),
        .padIn(boot_select_strap_pin),
        .padDriven(bootSelectDriven),
        .bitOut(straps.bootSelect)
    );

    // Hold window lets slow pull networks settle before release
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= bsl_pkg::BSL_ST_SAMPLE;
            holdCnt_reg <= 32'h0;
        end else if (ce) begin
            if (sysResetReq) begin
                state_reg <= bsl_pkg::BSL_ST_SAMPLE;
                holdCnt_reg <= 32'h0;
            end else begin
                unique case (state_reg)
                    bsl_pkg::BSL_ST_SAMPLE: begin
                        state_reg <= bsl_pkg::BSL_ST_HOLD;
                        holdCnt_reg <= 32'h0;
                    end
                    bsl_pkg::BSL_ST_HOLD: begin
                        if (holdCnt_reg == 32'(HOLD_CYCLES - 1)) begin
                            state_reg <= bsl_pkg::BSL_ST_RUN;
                        end else begin
                            holdCnt_reg <= holdCnt_reg + 32'h1;
                        end
                    end
                    bsl_pkg::BSL_ST_RUN: begin
                        state_reg <= bsl_pkg::BSL_ST_RUN;
                    end
                    default: begin
                        state_reg <= bsl_pkg::BSL_ST_SAMPLE;
                    end
                endcase
            end
        end
    end

    assign validReg = (state_reg == bsl_pkg::BSL_ST_RUN);

    // Software may hand pins back early only after latching is done
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            softRelease_reg <= 1'b0;
        end else if (ce) begin
            if (sysResetReq) begin
                softRelease_reg <= 1'b0;
            end else if (wr && addr == `BSL_OFF_CTRL && state_reg != bsl_pkg::BSL_ST_SAMPLE) begin
                softRelease_reg <= wdata[`BSL_BIT_RELEASE];
            end
        end
    end

    always_comb begin
        if (straps.bootSelect) begin
            bootMode = straps.secondary ? bsl_pkg::BSL_BOOT_FLASH : bsl_pkg::BSL_BOOT_UNDEF;
        end else if (straps.printAux) begin
            bootMode = bsl_pkg::BSL_BOOT_DOWNLOAD;
        end else begin
            bootMode = bsl_pkg::BSL_BOOT_INVALID;
        end
    end

    always_comb begin
        unique case (printControlFuse)
            `BSL_PRINT_ALWAYS: printEn = 1'b1;
            `BSL_PRINT_AUX_LOW: printEn = !straps.printAux;
            `BSL_PRINT_AUX_HIGH: printEn = straps.printAux;
            `BSL_PRINT_NEVER: printEn = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinsReleased <= 1'b0;
            flashBoot <= 1'b0;
            downloadBoot <= 1'b0;
            strapInvalid <= 1'b0;
            romPrintEn <= 1'b0;
        end else if (ce) begin
            if (sysResetReq) begin
                // Pins must come back to straps at once, or resampling sees I/O traffic
                pinsReleased <= 1'b0;
                flashBoot <= 1'b0;
                downloadBoot <= 1'b0;
                strapInvalid <= 1'b0;
                romPrintEn <= 1'b0;
            end else begin
                pinsReleased <= validReg || softRelease_reg;
                flashBoot <= validReg && bootMode == bsl_pkg::BSL_BOOT_FLASH;
                downloadBoot <= validReg && bootMode == bsl_pkg::BSL_BOOT_DOWNLOAD;
                strapInvalid <= validReg && bootMode == bsl_pkg::BSL_BOOT_INVALID;
                romPrintEn <= validReg && printEn;
            end
        end
    end

    // Read data valid the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 32'h0;
        end else if (ce) begin
            rdata <= 32'h0;
            if (rd) begin
                unique case (addr)
                    `BSL_OFF_STRAP: begin
                        rdata[`BSL_BIT_SECONDARY] <= straps.secondary;
                        rdata[`BSL_BIT_AUX] <= straps.printAux;
                        rdata[`BSL_BIT_SELECT] <= straps.bootSelect;
                        rdata[`BSL_BIT_VALID] <= validReg;
                    end
                    `BSL_OFF_BOOT: begin
                        rdata[`BSL_BIT_FLASH] <= flashBoot;
                        rdata[`BSL_BIT_DOWNLOAD] <= downloadBoot;
                        rdata[`BSL_BIT_INVALID] <= strapInvalid;
                        rdata[`BSL_BIT_PRINT] <= romPrintEn;
                    end
                    `BSL_OFF_CTRL: begin
                        rdata[`BSL_BIT_RELEASE] <= softRelease_reg;
                    end
                    default: begin
                        rdata <= 32'h0;
                    end
                endcase
            end
        end
    end
endmodule // bsl_boot_strap_latch

// [bench/bsl_strap_host.sv]
// Strap pin driver standing in for pull resistors or a host controller
`timescale 1ns/100ps
module bsl_strap_host (
    input wire logic clk,
    input wire logic released,
    input wire logic [2:0] level,
    input wire logic driveSel,
    output logic [2:0] pins,
    output logic selDriven
);
    logic toggleReg = 1'b0;
    // Released or floating pins wander so stale levels cannot pass
    always @(posedge clk) toggleReg <= ~toggleReg;
    assign selDriven = driveSel;
    assign pins[1:0] = released ? {toggleReg, ~toggleReg} : level[1:0];
    assign pins[2] = (released || !driveSel) ? toggleReg : level[2];
endmodule // bsl_strap_host

// [bench/bsl_checker.sv]
// Concurrent checks on the boot strap latch ports
`timescale 1ns/100ps
module bsl_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic sysResetReq,
    input wire logic [3:0] addr,
    input wire logic rd,
    input wire logic [1:0] printControlFuse,
    input wire logic [31:0] rdata,
    input wire logic pinsReleased,
    input wire logic flashBoot,
    input wire logic downloadBoot,
    input wire logic strapInvalid,
    input wire logic romPrintEn
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_rdata_idle_zero: assert property ((ce && !rd) ##1 ce |-> rdata == 32'h0) else $error("rdata not zero");
    a_unmapped_read: assert property (ce && rd && addr == 4'hc |=> rdata == 32'h0) else $error("unmapped read");
    a_reset_clears: assert property (sysResetReq |=> !flashBoot && !downloadBoot && !pinsReleased) else $error("not cleared");
    a_mode_onehot: assert property ($onehot0({flashBoot, downloadBoot, strapInvalid})) else $error("modes overlap");
    a_mode_stable: assert property (pinsReleased ##1 pinsReleased |-> $stable({flashBoot, downloadBoot, strapInvalid, romPrintEn}))
        else $error("mode moved");
    a_boot_read: assert property (ce && rd && addr == 4'h4 && pinsReleased |=>
        rdata[3:0] == $past({romPrintEn, strapInvalid, downloadBoot, flashBoot})) else $error("boot reg");
    a_download_aux: assert property (ce && rd && addr == 4'h0 && downloadBoot |=> rdata[2:1] == 2'h1)
        else $error("download straps");
    a_flash_straps: assert property (ce && rd && addr == 4'h0 && flashBoot |=> rdata[2] && rdata[0])
        else $error("flash straps");
    a_print_fuse: assert property (pinsReleased && $stable(printControlFuse) && printControlFuse[1] == printControlFuse[0]
        |-> romPrintEn == !printControlFuse[0]) else $error("print fuse");
    c_flash: cover property (flashBoot);
    c_download: cover property (downloadBoot);
    c_invalid: cover property (strapInvalid);
endmodule // bsl_checker
bind bsl_boot_strap_latch bsl_checker u_chk (.clk(clk), .rstn(rstn), .ce(ce), .sysResetReq(sysResetReq), .addr(addr),
    .rd(rd), .printControlFuse(printControlFuse), .rdata(rdata), .pinsReleased(pinsReleased), .flashBoot(flashBoot),
    .downloadBoot(downloadBoot), .strapInvalid(strapInvalid), .romPrintEn(romPrintEn));

// [bench/testbench.sv]
// Self-checking bench for the boot strap latch
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0, rstn = 1'b0, sysResetReq = 1'b0, wr = 1'b0, rd = 1'b0, driveSel = 1'b1, selDriven;
    logic pinsReleased, flashBoot, downloadBoot, strapInvalid, romPrintEn;
    logic [1:0] fuse = 2'h0;
    logic [2:0] level = 3'h7, pins;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    int error_cnt = 0, cmp_count = 0, cyc = 0;
    initial forever #5 clk = ~clk;
    bsl_strap_host host (.clk(clk), .released(pinsReleased), .level(level), .driveSel(driveSel), .pins(pins),
        .selDriven(selDriven));
    // Short hold keeps the run small
    bsl_boot_strap_latch #(.HOLD_CYCLES(4)) uut (.clk(clk), .rstn(rstn), .ce(1'b1), .sysResetReq(sysResetReq),
        .secondary_strap_pin(pins[0]), .print_aux_strap_pin(pins[1]), .boot_select_strap_pin(pins[2]),
        .bootSelectDriven(selDriven), .printControlFuse(fuse), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .pinsReleased(pinsReleased), .flashBoot(flashBoot), .downloadBoot(downloadBoot),
        .strapInvalid(strapInvalid), .romPrintEn(romPrintEn));
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_reg(logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wr_reg(logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic run_case(int i);
        int sel, aux, sec, f, exp, st;
        logic [31:0] got;
        @(posedge clk);
        level <= 3'(i);
        driveSel <= (i % 5) != 0;
        fuse <= 2'(i >> 3);
        if (i % 2 == 0) rstn <= 1'b0;
        else sysResetReq <= 1'b1;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        sysResetReq <= 1'b0;
        for (int n = 0; n < 50 && pinsReleased !== 1'b1; n++) @(negedge clk);
        // Floating select pin reads as one
        sel = ((i % 5) != 0) ? (i >> 2) & 1 : 1;
        aux = (i >> 1) & 1;
        sec = i & 1;
        f = (i >> 3) & 3;
        exp = (sel & sec) | ((!sel && aux) << 1) | ((!sel && !aux) << 2);
        exp |= (f == 0 || (f == 1 && !aux) || (f == 2 && aux)) << 3;
        st = 8 | (sel << 2) | (aux << 1) | sec;
        check("release", {31'h0, pinsReleased}, 32'h1);
        check("mode", {28'h0, romPrintEn, strapInvalid, downloadBoot, flashBoot}, 32'(exp));
        rd_reg(4'h4, got);
        check("boot reg", got, 32'(exp));
        wr_reg(4'h0, $urandom);
        rd_reg(4'h0, got);
        check("strap reg", got, 32'(st));
        rd_reg(4'hc, got);
        check("unmapped", got, 32'h0);
        rd_reg(4'h8, got);
        check("ctrl clear", got, 32'h0);
        wr_reg(4'h8, 32'h1);
        rd_reg(4'h8, got);
        check("ctrl set", got, 32'h1);
        repeat (6) @(posedge clk);
        rd_reg(4'h0, got);
        check("strap held", got, 32'(st));
        $display("test %0d done", i);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(62675));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 32; i++) run_case(i);
        complete_run();
    end
endmodule // testbench
